// >>> logic/tcsa_pkg.sv
// Shared constants and types for the temperature conversion sequencer with alarms
package tcsa_pkg;

   // ==========================================================================
   // Channels and data
   // ==========================================================================
   localparam int              NUM_CH      = 5;
   localparam int              CH_W        = 3;
   localparam int              DATA_W      = 8;
   localparam int              ADDR_W      = 8;
   localparam logic [CH_W-1:0] CH_REMOTE1  = 3'h0;
   localparam logic [CH_W-1:0] CH_REMOTE2  = 3'h1;
   localparam logic [CH_W-1:0] CH_REMOTE4  = 3'h3;
   localparam logic [CH_W-1:0] CH_LOCAL    = 3'h4;

   // ==========================================================================
   // Register offsets (byte addresses, one aligned word each)
   // ==========================================================================
   localparam logic [ADDR_W-1:0] OFF_TEMP0    = 8'h00;
   localparam logic [ADDR_W-1:0] OFF_ALERT0   = 8'h14;
   localparam logic [ADDR_W-1:0] OFF_OT1      = 8'h28;
   localparam logic [ADDR_W-1:0] OFF_OT4      = 8'h2C;
   localparam logic [ADDR_W-1:0] OFF_CONFIG   = 8'h30;
   localparam logic [ADDR_W-1:0] OFF_STATUS   = 8'h34;
   localparam logic [ADDR_W-1:0] OFF_INT_STAT = 8'h38;
   localparam logic [ADDR_W-1:0] OFF_INT_MASK = 8'h3C;

   // ==========================================================================
   // Field positions
   // ==========================================================================
   localparam int CFG_FAST_BIT  = 4;
   localparam int STAT_OT1_BIT  = 5;
   localparam int STAT_OT4_BIT  = 6;
   localparam int EVT_CYCLE_BIT = 7;

   // ==========================================================================
   // Values after reset
   // ==========================================================================
   localparam logic [DATA_W-1:0] TEMP_RST      = 8'h00;
   localparam logic [DATA_W-1:0] ALERT_THR_RST = 8'h55;
   localparam logic [DATA_W-1:0] OT_THR_RST    = 8'h6E;
   localparam logic [7:0]        CONFIG_RST    = 8'h00;
   localparam logic [7:0]        INT_MASK_RST  = 8'h00;

   // ==========================================================================
   // Sequencer states
   // ==========================================================================
   typedef enum logic [1:0] {
      SEQ_IDLE  = 2'b00,
      SEQ_START = 2'b01,
      SEQ_WAIT  = 2'b10
   } tcsa_seq_state_type;

endpackage : tcsa_pkg

// >>> logic/tcsa_conv_seq.sv
// Conversion sequencer: picks the channel for each conversion
`timescale 1ns/1ps
`default_nettype none

module tcsa_conv_seq (
   input  wire logic                     mclk,
   input  wire logic                     rst_n,
   input  wire logic                     fast_mode,
   input  wire logic                     conv_done,
   output logic                          conv_start,
   output logic [tcsa_pkg::CH_W-1:0]     conv_chan
);

   // ==========================================================================
   // State
   // ==========================================================================
   tcsa_pkg::tcsa_seq_state_type    state_reg;
   tcsa_pkg::tcsa_seq_state_type    state_next;
   logic [tcsa_pkg::CH_W-1:0]       chan_reg;
   logic [tcsa_pkg::CH_W-1:0]       chan_next;
   logic [tcsa_pkg::CH_W-1:0]       other_reg;
   logic [tcsa_pkg::CH_W-1:0]       other_next;
   logic                            step;

   assign step       = (state_reg == tcsa_pkg::SEQ_WAIT) && conv_done;
   assign conv_start = (state_reg == tcsa_pkg::SEQ_START);
   assign conv_chan  = chan_reg;

   always_comb begin
      state_next = state_reg;
      case (state_reg)
         tcsa_pkg::SEQ_IDLE:  state_next = tcsa_pkg::SEQ_START;
         tcsa_pkg::SEQ_START: state_next = tcsa_pkg::SEQ_WAIT;
         tcsa_pkg::SEQ_WAIT: begin
            if (conv_done) begin
               state_next = tcsa_pkg::SEQ_START;
            end
         end
         default:             state_next = tcsa_pkg::SEQ_IDLE;
      endcase
   end

   // ==========================================================================
   // Channel order
   // ==========================================================================
   // A mode change takes effect at the next channel step, never mid-conversion
   always_comb begin
      chan_next  = chan_reg;
      other_next = other_reg;
      if (fast_mode) begin
         if (chan_reg == tcsa_pkg::CH_REMOTE1) begin
            chan_next = other_reg;
         end else begin
            chan_next = tcsa_pkg::CH_REMOTE1;
            other_next = (chan_reg == tcsa_pkg::CH_LOCAL) ? tcsa_pkg::CH_REMOTE2
                                                         : chan_reg + 3'h1;
         end
      end else begin
         chan_next = (chan_reg == tcsa_pkg::CH_LOCAL) ? tcsa_pkg::CH_REMOTE1
                                                     : chan_reg + 3'h1;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= tcsa_pkg::SEQ_IDLE;
      end else begin
         state_reg <= state_next;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         chan_reg  <= tcsa_pkg::CH_REMOTE1;
         other_reg <= tcsa_pkg::CH_REMOTE2;
      end else if (step) begin
         chan_reg  <= chan_next;
         other_reg <= other_next;
      end
   end

endmodule : tcsa_conv_seq

`default_nettype wire

// >>> logic/tcsa_temp_monitor.sv
// Temperature monitor top: sequencing, result store, thresholds, alarms, APB
// Operation
// - Default order: channel 1, 2, 3, then onward to local, repeating.
// - Each conversion result is stored in that channel's temperature register.
// - Configuration bit 4 set selects fast channel 1 mode; clear selects default.
// - Fast mode puts a channel 1 measurement between every other channel.
// - Alert threshold for every channel; overtemperature threshold for channels 1, 4.
// - Overtemperature output pulled low while channel 1 or 4 exceeds its limit.
// - Alert output pulled low while any channel exceeds its alert threshold.
// - Exceeded thresholds set status bits; both alarm outputs follow them.
`timescale 1ns/1ps
`default_nettype none

module tcsa_temp_monitor (
   input  wire logic                          mclk,
   input  wire logic                          rst_n,
   // APB slave
   input  wire logic                          psel,
   input  wire logic                          penable,
   input  wire logic                          pwrite,
   input  wire logic [tcsa_pkg::ADDR_W-1:0]   paddr,
   input  wire logic [31:0]                   pwdata,
   output logic      [31:0]                   prdata,
   output logic                               pready,
   output logic                               pslverr,
   // Converter handshake
   output logic                               conv_start,
   output logic      [tcsa_pkg::CH_W-1:0]     conv_chan,
   input  wire logic                          conv_done,
   input  wire logic [tcsa_pkg::DATA_W-1:0]   conv_data,
   // Open-drain alarm pins
   output logic                               alert_out,
   output logic                               alert_oe,
   output logic                               overtemp_alarm_out,
   output logic                               overtemp_alarm_oe,
   // Interrupt
   output logic                               irq
);

   // ==========================================================================
   // Declarations
   // ==========================================================================
   localparam int NCH = tcsa_pkg::NUM_CH;
   localparam int DW  = tcsa_pkg::DATA_W;

   logic [DW-1:0]   temp_reg      [NCH];
   logic [DW-1:0]   alert_thr_reg [NCH];
   logic [DW-1:0]   ot_thr_reg    [2];
   logic [7:0]      config_reg;
   logic [NCH-1:0]  alert_stat_reg;
   logic [1:0]      ot_stat_reg;
   logic [7:0]      int_stat_reg;
   logic [7:0]      int_mask_reg;
   logic [31:0]     prdata_reg;

   logic            setup_phase;
   logic            access_phase;
   logic            wr_en;
   logic            rd_en;
   logic            addr_hit;
   logic [31:0]     rd_mux;
   logic [NCH-1:0]  alert_rise;
   logic [1:0]      ot_rise;
   logic [7:0]      int_events;
   logic [7:0]      int_clear;
   logic            fast_mode;

   // ==========================================================================
   // Conversion sequencer
   // ==========================================================================
   assign fast_mode = config_reg[tcsa_pkg::CFG_FAST_BIT];

   tcsa_conv_seq u_seq (
      .mclk       (mclk),
      .rst_n      (rst_n),
      .fast_mode  (fast_mode),
      .conv_done  (conv_done),
      .conv_start (conv_start),
      .conv_chan  (conv_chan)
   );

   // ==========================================================================
   // APB decode
   // ==========================================================================
   // Zero wait states: every access completes in its first access cycle
   assign setup_phase  = psel && !penable;
   assign access_phase = psel && penable;
   assign wr_en        = access_phase && pwrite && addr_hit;
   assign rd_en        = access_phase && !pwrite && addr_hit;
   assign pready       = 1'b1;
   assign pslverr      = access_phase && !addr_hit;
   assign prdata       = prdata_reg;

   always_comb begin
      addr_hit = 1'b0;
      rd_mux   = 32'h0000_0000;
      for (int k = 0; k < NCH; k++) begin
         if (paddr == 8'(tcsa_pkg::OFF_TEMP0 + 4 * k)) begin
            addr_hit = 1'b1;
            rd_mux   = {24'h00_0000, temp_reg[k]};
         end
         if (paddr == 8'(tcsa_pkg::OFF_ALERT0 + 4 * k)) begin
            addr_hit = 1'b1;
            rd_mux   = {24'h00_0000, alert_thr_reg[k]};
         end
      end
      case (paddr)
         tcsa_pkg::OFF_OT1: begin
            addr_hit = 1'b1;
            rd_mux   = {24'h00_0000, ot_thr_reg[0]};
         end
         tcsa_pkg::OFF_OT4: begin
            addr_hit = 1'b1;
            rd_mux   = {24'h00_0000, ot_thr_reg[1]};
         end
         tcsa_pkg::OFF_CONFIG: begin
            addr_hit = 1'b1;
            rd_mux   = {24'h00_0000, config_reg};
         end
         tcsa_pkg::OFF_STATUS: begin
            addr_hit = 1'b1;
            rd_mux   = {25'h000_0000, ot_stat_reg, alert_stat_reg};
         end
         tcsa_pkg::OFF_INT_STAT: begin
            addr_hit = 1'b1;
            rd_mux   = {24'h00_0000, int_stat_reg};
         end
         tcsa_pkg::OFF_INT_MASK: begin
            addr_hit = 1'b1;
            rd_mux   = {24'h00_0000, int_mask_reg};
         end
         default: begin
         end
      endcase
   end

   // Read data is captured in the setup cycle so it comes from a flip-flop
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         prdata_reg <= 32'h0000_0000;
      end else if (setup_phase) begin
         prdata_reg <= pwrite ? 32'h0000_0000 : rd_mux;
      end
   end

   // ==========================================================================
   // Configuration and interrupt mask
   // ==========================================================================
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         config_reg <= tcsa_pkg::CONFIG_RST;
      end else if (wr_en && paddr == tcsa_pkg::OFF_CONFIG) begin
         config_reg <= pwdata[7:0];
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         int_mask_reg <= tcsa_pkg::INT_MASK_RST;
      end else if (wr_en && paddr == tcsa_pkg::OFF_INT_MASK) begin
         int_mask_reg <= pwdata[7:0];
      end
   end

   // ==========================================================================
   // Per-channel result store and alert comparison
   // ==========================================================================
   // Status follows the stored result only; a threshold write alone does not
   // re-evaluate it, so the next conversion of that channel settles it
   for (genvar i = 0; i < NCH; i++) begin : g_chan
      localparam logic [tcsa_pkg::ADDR_W-1:0] THR_ADDR =
         8'(tcsa_pkg::OFF_ALERT0 + 4 * i);
      logic hit;
      logic over;

      assign hit           = conv_done && (conv_chan == tcsa_pkg::CH_W'(i));
      assign over          = conv_data > alert_thr_reg[i];
      assign alert_rise[i] = hit && over && !alert_stat_reg[i];

      always_ff @(posedge mclk or negedge rst_n) begin
         if (!rst_n) begin
            temp_reg[i] <= tcsa_pkg::TEMP_RST;
         end else if (hit) begin
            temp_reg[i] <= conv_data;
         end
      end

      always_ff @(posedge mclk or negedge rst_n) begin
         if (!rst_n) begin
            alert_thr_reg[i] <= tcsa_pkg::ALERT_THR_RST;
         end else if (wr_en && paddr == THR_ADDR) begin
            alert_thr_reg[i] <= pwdata[DW-1:0];
         end
      end

      always_ff @(posedge mclk or negedge rst_n) begin
         if (!rst_n) begin
            alert_stat_reg[i] <= 1'b0;
         end else if (hit) begin
            alert_stat_reg[i] <= over;
         end
      end
   end

   // ==========================================================================
   // Overtemperature thresholds, channels 1 and 4 only
   // ==========================================================================
   for (genvar j = 0; j < 2; j++) begin : g_ot
      localparam logic [tcsa_pkg::CH_W-1:0]   OT_CHAN =
         (j == 0) ? tcsa_pkg::CH_REMOTE1 : tcsa_pkg::CH_REMOTE4;
      localparam logic [tcsa_pkg::ADDR_W-1:0] OT_ADDR =
         (j == 0) ? tcsa_pkg::OFF_OT1 : tcsa_pkg::OFF_OT4;
      logic hit;
      logic over;

      assign hit        = conv_done && (conv_chan == OT_CHAN);
      assign over       = conv_data > ot_thr_reg[j];
      assign ot_rise[j] = hit && over && !ot_stat_reg[j];

      always_ff @(posedge mclk or negedge rst_n) begin
         if (!rst_n) begin
            ot_thr_reg[j] <= tcsa_pkg::OT_THR_RST;
         end else if (wr_en && paddr == OT_ADDR) begin
            ot_thr_reg[j] <= pwdata[DW-1:0];
         end
      end

      always_ff @(posedge mclk or negedge rst_n) begin
         if (!rst_n) begin
            ot_stat_reg[j] <= 1'b0;
         end else if (hit) begin
            ot_stat_reg[j] <= over;
         end
      end
   end

   // ==========================================================================
   // Alarm pins
   // ==========================================================================
   // Open drain: the pin is only ever pulled low, never driven high
   assign alert_out          = 1'b0;
   assign alert_oe           = |alert_stat_reg;
   assign overtemp_alarm_out = 1'b0;
   assign overtemp_alarm_oe  = |ot_stat_reg;

   // ==========================================================================
   // Interrupt status
   // ==========================================================================
   assign int_events[NCH-1:0]                = alert_rise;
   assign int_events[tcsa_pkg::STAT_OT1_BIT] = ot_rise[0];
   assign int_events[tcsa_pkg::STAT_OT4_BIT] = ot_rise[1];
   assign int_events[tcsa_pkg::EVT_CYCLE_BIT] =
      conv_done && (conv_chan == tcsa_pkg::CH_LOCAL);

   // Only bits that the read returned are cleared, so an event landing
   // between the setup and access cycles survives; a new event beats a clear
   assign int_clear = (rd_en && paddr == tcsa_pkg::OFF_INT_STAT) ?
                      prdata_reg[7:0] : 8'h00;

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         int_stat_reg <= 8'h00;
      end else begin
         int_stat_reg <= (int_stat_reg & ~int_clear) | int_events;
      end
   end

   assign irq = |(int_stat_reg & int_mask_reg);

endmodule : tcsa_temp_monitor

`default_nettype wire

// >>> dv/tcsa_temp_monitor_chk.sv
// Port checker for the temperature monitor
`timescale 1ns/1ps
`default_nettype none
module tcsa_temp_monitor_chk (
   input wire logic                        mclk,
   input wire logic                        rst_n,
   input wire logic                        psel,
   input wire logic                        penable,
   input wire logic [31:0]                 prdata,
   input wire logic                        pready,
   input wire logic                        pslverr,
   input wire logic                        conv_start,
   input wire logic [tcsa_pkg::CH_W-1:0]   conv_chan,
   input wire logic                        conv_done,
   input wire logic                        alert_out,
   input wire logic                        alert_oe,
   input wire logic                        overtemp_alarm_out,
   input wire logic                        overtemp_alarm_oe,
   input wire logic                        irq
);
   // =====
   // Helper: last request was the local channel
   logic after_local_reg;
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) after_local_reg <= 1'b0;
      else if (conv_start) after_local_reg <= (conv_chan == tcsa_pkg::CH_LOCAL);
   end
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);
   // =====
   // Assertions
   a_start_one_cycle: assert property (conv_start |=> !conv_start)
      else $error("conversion request too long");
   a_done_then_start: assert property (conv_done |=> conv_start)
      else $error("no request after a result");
   a_start_has_cause: assert property (conv_start |-> $past(conv_done) || !$past(rst_n, 2))
      else $error("request without a result");
   a_local_then_ch1: assert property (conv_start && after_local_reg |-> conv_chan == 3'h0)
      else $error("local not followed by channel 1");
   a_chan_steady: assert property (!$past(conv_done) |-> $stable(conv_chan))
      else $error("channel moved during conversion");
   a_alarm_settle: assert property (!$past(conv_done) |-> $stable({alert_oe, overtemp_alarm_oe}))
      else $error("alarm moved without a result");
   a_pins_pull_low: assert property (!alert_out && !overtemp_alarm_out)
      else $error("alarm pin driven high");
   a_err_access_only: assert property (pslverr |-> psel && penable && prdata == 32'h0)
      else $error("error outside access");
   a_read_ready: assert property (psel && penable |-> pready && prdata[31:8] == 24'h0)
      else $error("wait state or wide read data");
   c_ch4_request: cover property (conv_start && conv_chan == tcsa_pkg::CH_REMOTE4);
   c_alert_drop: cover property (alert_oe ##1 !alert_oe);
   c_overtemp: cover property (overtemp_alarm_oe);
   c_irq: cover property (irq);
endmodule : tcsa_temp_monitor_chk
bind tcsa_temp_monitor tcsa_temp_monitor_chk u_chk (.mclk(mclk), .rst_n(rst_n), .psel(psel),
   .penable(penable), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .conv_start(conv_start), .conv_chan(conv_chan), .conv_done(conv_done), .alert_out(alert_out),
   .alert_oe(alert_oe), .overtemp_alarm_out(overtemp_alarm_out),
   .overtemp_alarm_oe(overtemp_alarm_oe), .irq(irq));
`default_nettype wire

// >>> dv/tcsa_conv_model.sv
// Behavioural converter answering conversion requests
`timescale 1ns/1ps
`default_nettype none
module tcsa_conv_model (
   input  wire logic                        mclk,
   input  wire logic                        rst_n,
   input  wire logic                        conv_start,
   input  wire logic [tcsa_pkg::CH_W-1:0]   conv_chan,
   input  wire logic [39:0]                 temps,
   input  wire logic [7:0]                  delay,
   output logic                             conv_done,
   output logic      [tcsa_pkg::DATA_W-1:0] conv_data
);
   logic       busy_reg;
   logic [7:0] cnt_reg;
   logic [2:0] chan_reg;
   // =====
   // Latency fixed when a request is seen; data toggles outside a result
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         busy_reg <= 1'b0;
         cnt_reg <= 8'h00;
         chan_reg <= 3'h0;
         conv_done <= 1'b0;
         conv_data <= 8'h00;
      end else if (conv_start) begin
         busy_reg <= 1'b1;
         cnt_reg <= delay;
         chan_reg <= conv_chan;
         conv_done <= 1'b0;
         conv_data <= ~conv_data;
      end else if (busy_reg && cnt_reg == 8'h00) begin
         busy_reg <= 1'b0;
         conv_done <= 1'b1;
         conv_data <= temps[chan_reg*8 +: 8];
      end else begin
         cnt_reg <= cnt_reg - 8'h01;
         conv_done <= 1'b0;
         conv_data <= ~conv_data;
      end
   end
endmodule : tcsa_conv_model
`default_nettype wire

// >>> dv/temp_conversion_sequencer_alarms_bench.sv
// Self-checking bench for the temperature monitor
`timescale 1ns/1ps
`default_nettype none
module temp_conversion_sequencer_alarms_bench;
   logic        mclk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00, delay = 8'hC8, conv_data;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic [39:0] temps = 40'h0;
   logic [2:0]  conv_chan;
   logic        pready, pslverr, conv_start, conv_done, err, al_out, al_oe, ot_out, ot_oe, irq;
   logic [7:0]  thr_m[7] = '{8'h55, 8'h55, 8'h55, 8'h55, 8'h55, 8'h6E, 8'h6E};
   logic [7:0]  temp_m[5] = '{default: 8'h00};
   logic [7:0]  stat_m = 8'h00, istat_m = 8'h00, mask_m = 8'h00, cfg_m = 8'h00;
   int          failures = 0, checks = 0, pos = 0, hold = 0, dones = 0;
   always #10 mclk = ~mclk;
   tcsa_temp_monitor DUT (.mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .conv_start(conv_start), .conv_chan(conv_chan), .conv_done(conv_done),
      .conv_data(conv_data), .alert_out(al_out), .alert_oe(al_oe), .overtemp_alarm_out(ot_out),
      .overtemp_alarm_oe(ot_oe), .irq(irq));
   tcsa_conv_model u_model (.mclk(mclk), .rst_n(rst_n), .conv_start(conv_start),
      .conv_chan(conv_chan), .temps(temps), .delay(delay), .conv_done(conv_done),
      .conv_data(conv_data));
   // =====
   // Checking and closing
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         failures++;
         $display("unexpected %s: expected %h seen %h", name, exp, seen);
      end
   endtask : check
   task automatic stop_test;
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : stop_test
   task automatic wait_edge(input bit stop, inout int n);
      @(posedge mclk);
      n++;
      if (n > 1000) begin
         failures++;
         stop_test();
      end
   endtask : wait_edge
   // =====
   // APB master and register model
   task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d);
      int n;
      n = 0;
      @(posedge mclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= {24'h0, d};
      @(posedge mclk);
      penable <= 1'b1;
      do wait_edge(1'b0, n); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      check("pslverr", err, a > 8'h3C);
   endtask : apb
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      apb(1'b1, a, d);
      if (a >= 8'h14 && a <= 8'h2C) thr_m[(a - 8'h14) >> 2] = d;
      if (a == tcsa_pkg::OFF_CONFIG) cfg_m = d;
      if (a == tcsa_pkg::OFF_CONFIG) hold = 2;
      if (a == tcsa_pkg::OFF_INT_MASK) mask_m = d;
   endtask : wr_reg
   function automatic logic [7:0] exp_rd(input logic [7:0] a);
      if (a <= 8'h10) return temp_m[a >> 2];
      if (a <= 8'h2C) return thr_m[(a - 8'h14) >> 2];
      case (a)
         8'h30: return cfg_m;
         8'h34: return stat_m;
         8'h38: return istat_m;
         8'h3C: return mask_m;
         default: return 8'h00;
      endcase
   endfunction : exp_rd
   // Reads only while the converter is held off, so no event races a read-clear
   // The first request may still carry a short latency; the second cannot
   task automatic quiet_dump;
      int n;
      n = 0;
      delay <= 8'hC8;
      repeat (2) begin
         do wait_edge(1'b0, n); while (conv_start !== 1'b1);
      end
      for (int a = 0; a <= 8'h40; a += 4) begin
         apb(1'b0, 8'(a), 8'h00);
         check("read data", rd, {24'h0, exp_rd(8'(a))});
         if (a == 8'h38) istat_m = 8'h00;
      end
      @(negedge mclk);
      check("irq", irq, |(istat_m & mask_m));
   endtask : quiet_dump
   task automatic upd(input int b, input logic [7:0] d);
      if (d > thr_m[b] && !stat_m[b]) istat_m[b] = 1'b1;
      stat_m[b] = d > thr_m[b];
   endtask : upd
   function automatic logic [2:0] exp_ch(input int p);
      if (cfg_m[4]) return (p % 2 == 0) ? 3'h0 : 3'(p / 2 + 1);
      return 3'(p);
   endfunction : exp_ch
   // =====
   // Converter monitor; a mode change resyncs at the first local request after the next request
   always @(posedge mclk) begin
      if (rst_n && conv_start === 1'b1 && hold == 0) begin
         check("channel", conv_chan, exp_ch(pos));
         pos = (pos + 1) % (cfg_m[4] ? 8 : 5);
      end else if (rst_n && conv_start === 1'b1) begin
         if (hold == 1 && conv_chan === tcsa_pkg::CH_LOCAL) pos = 0;
         if (hold > 1 || conv_chan === tcsa_pkg::CH_LOCAL) hold--;
      end
      if (rst_n && conv_done === 1'b1) begin
         dones++;
         temp_m[conv_chan] = conv_data;
         upd(conv_chan, conv_data);
         if (conv_chan == 3'h0) upd(5, conv_data);
         if (conv_chan == 3'h3) upd(6, conv_data);
         if (conv_chan == 3'h4) istat_m[7] = 1'b1;
         @(negedge mclk);
         check("alert", al_oe, |stat_m[4:0]);
         check("overtemp", ot_oe, |stat_m[6:5]);
         check("irq", irq, |(istat_m & mask_m));
      end
   end
   initial begin
      int n, d;
      void'($urandom(6759));
      repeat (3) @(posedge mclk);
      rst_n <= 1'b1;
      apb(1'b1, 8'h00, 8'hAB);
      apb(1'b1, 8'h40, 8'hAB);
      quiet_dump();
      for (int i = 0; i < 7; i++) wr_reg(8'h14 + 8'(4 * i), 8'($urandom_range(8'h40, 8'hA0)));
      for (int r = 0; r < 4; r++) begin
         wr_reg(tcsa_pkg::OFF_INT_MASK, 8'($urandom));
         wr_reg(tcsa_pkg::OFF_CONFIG, r[0] ? 8'h10 : 8'h00);
         for (int k = 0; k < 24; k++) begin
            temps <= {$urandom, 8'($urandom)};
            delay <= 8'($urandom_range(0, 3));
            d = dones;
            n = 0;
            do wait_edge(1'b0, n); while (dones == d);
         end
         quiet_dump();
      end
      stop_test();
   end
endmodule : temp_conversion_sequencer_alarms_bench
`default_nettype wire
